/* File: rtl/shift_reg_pkg.sv */
// Purpose: constants for the recirculating shift register
// Assumes: one 20 MHz clock domain
// Notes:   chain lengths of the two variants
package shift_reg_pkg;
   // =====================================================
   // chain lengths
   localparam int SHORT_LEN   = 32;
   localparam int LONG_LEN    = 40;
   localparam int DEFAULT_LEN = SHORT_LEN;
   // =====================================================
   // reset values
   localparam logic RESET_BIT = 1'b0;
   localparam logic SYNC_INIT = 1'b0;
   // idle levels of the shift clock and enable pins
   localparam logic CLK_SYNC_INIT = 1'h1;
   localparam logic OE_SYNC_INIT  = 1'h1;
endpackage

/* File: rtl/bit_chain.sv */
// Purpose: serial storage chain, one place per enabled shift
// Assumes: shift qualified by caller
// Notes:   tail bit comes out of a register
`timescale 1ns/1ps
module bit_chain
#(
   parameter int LEN = shift_reg_pkg::DEFAULT_LEN
)
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic shiftEn,
   input  wire logic headBit,
   output logic      tailBit
);
   import shift_reg_pkg::*;

   // =====================================================
   // elaboration check
   // head and tail need two distinct places
   if (LEN < 2)
   begin : g_shortChain
      $error("LEN must be at least two");
   end

   logic [LEN-1:0] chain_reg;
   logic [LEN-1:0] chain_next;

   // =====================================================
   // shift path
   // advance one place
   assign chain_next = {chain_reg[LEN-2:0], headBit};
   assign tailBit    = chain_reg[LEN-1];

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         chain_reg <= {LEN{RESET_BIT}};
      else if (shiftEn)
         chain_reg <= chain_next;
   end
endmodule // bit_chain

/* File: rtl/recirc_shift_reg.sv */
// Purpose: recirculating static shift register, 32 or 40 bits
// Assumes: pins arrive asynchronously; 20 MHz system clock
// Notes:   pin shift clock is sampled, a rising edge shifts
`timescale 1ns/1ps
module recirc_shift_reg
#(
   parameter int LEN = shift_reg_pkg::DEFAULT_LEN
)
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic clkEn,
   input  wire logic shiftClk,
   input  wire logic dataIn,
   input  wire logic recirculate,
   input  wire logic outEnable_n,
   output logic      dataOut,
   output logic      dataOutEn
);
   import shift_reg_pkg::*;

   // =====================================================
   // elaboration check
   // the chain is only built in its two lengths
   if (LEN != SHORT_LEN && LEN != LONG_LEN)
   begin : g_badLen
      $error("LEN must be one of the two chain lengths");
   end

   // =====================================================
   // helpers
   // one synchroniser step, shared by all four pins
   function automatic logic [1:0] syncStep(input logic [1:0] stages,
                                           input logic       pin);
      return {stages[0], pin};
   endfunction

   // =====================================================
   // input synchronisers
   logic [1:0] clkSync_reg;
   logic [1:0] clkSync_next;
   logic [1:0] dataSync_reg;
   logic [1:0] dataSync_next;
   logic [1:0] recSync_reg;
   logic [1:0] recSync_next;
   logic [1:0] oeSync_reg;
   logic [1:0] oeSync_next;
   logic       clkPrev_reg;
   logic       dataOut_reg;
   logic       dataOutEn_reg;

   // only the second stage of each pair feeds logic
   assign clkSync_next  = syncStep(clkSync_reg, shiftClk);
   assign dataSync_next = syncStep(dataSync_reg, dataIn);
   assign recSync_next  = syncStep(recSync_reg, recirculate);
   assign oeSync_next   = syncStep(oeSync_reg, outEnable_n);

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         // presets match idle pins, so no edge after reset
         clkSync_reg  <= {2{CLK_SYNC_INIT}};
         dataSync_reg <= {2{SYNC_INIT}};
         recSync_reg  <= {2{SYNC_INIT}};
         oeSync_reg   <= {2{OE_SYNC_INIT}};
         clkPrev_reg  <= CLK_SYNC_INIT;
      end
      else if (clkEn)
      begin
         clkSync_reg  <= clkSync_next;
         dataSync_reg <= dataSync_next;
         recSync_reg  <= recSync_next;
         oeSync_reg   <= oeSync_next;
         clkPrev_reg  <= clkSync_reg[1];
      end
   end

   // =====================================================
   // shift decode
   // pin must stay high and low one clock each
   // halted high gives no edge
   wire shiftEdge = clkEn && clkSync_reg[1] && !clkPrev_reg;
   wire tailBit;
   wire headBit   = recSync_reg[1] ? tailBit : dataSync_reg[1];

   bit_chain #(.LEN(LEN)) chainInst
   (
      .clk     (clk),
      .reset_n (reset_n),
      .shiftEn (shiftEdge),
      .headBit (headBit),
      .tailBit (tailBit)
   );

   // =====================================================
   // output stage; enable kept separate, pad resolves level
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         dataOut_reg   <= RESET_BIT;
         dataOutEn_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         dataOut_reg   <= tailBit;
         dataOutEn_reg <= !oeSync_reg[1];
      end
   end
   assign dataOut   = dataOut_reg;
   assign dataOutEn = dataOutEn_reg;

   // =====================================================
   // checks
   // enable follows pin
   property p_outen;
      @(posedge clk) disable iff (!reset_n)
      clkEn ##1 clkEn |-> dataOutEn == !$past(oeSync_reg[1]);
   endproperty
   a_outen: assert property (p_outen) else $error("enable mismatch");

   property p_pinToEn;
      @(posedge clk) disable iff (!reset_n)
      clkEn ##1 clkEn ##1 clkEn ##1 1'h1 |-> dataOutEn == !$past(outEnable_n, 3);
   endproperty
   a_pinToEn: assert property (p_pinToEn) else $error("enable latency wrong");

   property p_data;
      @(posedge clk) disable iff (!reset_n)
      clkEn ##1 clkEn |-> dataOut == $past(tailBit);
   endproperty
   a_data: assert property (p_data) else $error("data out mismatch");

   property p_resetOut;
      @(posedge clk)
      !reset_n |=> dataOut == RESET_BIT && !dataOutEn;
   endproperty
   a_resetOut: assert property (p_resetOut) else $error("outputs not cleared");

   property p_recirc;
      @(posedge clk) disable iff (!reset_n)
      shiftEdge && recSync_reg[1] |=> chainInst.chain_reg[0] == $past(tailBit);
   endproperty
   a_recirc: assert property (p_recirc) else $error("recirc wrong");

   property p_write;
      @(posedge clk) disable iff (!reset_n)
      shiftEdge && !recSync_reg[1] |=> chainInst.chain_reg[0] == $past(dataSync_reg[1]);
   endproperty
   a_write: assert property (p_write) else $error("write wrong");

   property p_hold;
      @(posedge clk) disable iff (!reset_n)
      !shiftEdge |=> $stable(tailBit);
   endproperty
   a_hold: assert property (p_hold) else $error("chain moved");

   property p_advance;
      @(posedge clk) disable iff (!reset_n)
      shiftEdge |=> tailBit == $past(chainInst.chain_reg[LEN-2]);
   endproperty
   a_advance: assert property (p_advance) else $error("chain did not advance");

   property p_oneShift;
      @(posedge clk) disable iff (!reset_n)
      shiftEdge |=> !shiftEdge;
   endproperty
   a_oneShift: assert property (p_oneShift) else $error("double shift");

   property p_riseShifts;
      @(posedge clk) disable iff (!reset_n)
      (clkEn && !shiftClk) ##1 (clkEn && shiftClk) ##1 clkEn ##1 clkEn |-> shiftEdge;
   endproperty
   a_riseShifts: assert property (p_riseShifts) else $error("rise not shifted");

   property p_freeze;
      @(posedge clk) disable iff (!reset_n)
      !clkEn |=> $stable(tailBit) && $stable(dataOut) && $stable(dataOutEn);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   property p_nohalt;
      @(posedge clk) disable iff (!reset_n)
      $past(clkEn) && clkSync_reg[1] && $past(clkSync_reg[1]) |-> !shiftEdge;
   endproperty
   a_nohalt: assert property (p_nohalt) else $error("shift while high");

   // =====================================================
   // main scenarios
   c_shift:  cover property (@(posedge clk) shiftEdge && recSync_reg[1]);
   c_write:  cover property (@(posedge clk) shiftEdge && !recSync_reg[1]);
   c_tri:    cover property (@(posedge clk) !dataOutEn ##1 dataOutEn);
   c_hiz:    cover property (@(posedge clk) dataOutEn ##1 !dataOutEn);
   c_freeze: cover property (@(posedge clk) !clkEn && !shiftClk);
endmodule // recirc_shift_reg

/* File: tb/shift_driver.sv */
// Purpose: controller model for shift clock, data, mode
// Assumes: bench calls pulse between shifts
// Notes:   clock parks high between pulses
`timescale 1ns/1ps
module shift_driver
(
   input  wire logic clk,
   output logic      shiftClk,
   output logic      dataIn,
   output logic      recirculate
);
   initial
   begin
      shiftClk    = 1'b1;
      dataIn      = 1'b0;
      recirculate = 1'b1;
   end
   // =====================
   // one shift
   // data and mode held over the rise
   task automatic pulse(input logic d, input logic r);
      @(negedge clk);
      dataIn      = d;
      recirculate = r;
      shiftClk    = 1'b0;
      repeat (4) @(negedge clk);
      shiftClk = 1'b1;
      repeat (4) @(negedge clk);
   endtask
endmodule // shift_driver

/* File: tb/testbench.sv */
// Purpose: self-checking bench, 32-bit variant
// Assumes: inputs change on the falling edge
// Notes:   fixed waits only, so no hang is possible
`timescale 1ns/1ps
module testbench;
   import shift_reg_pkg::*;
   logic clk, reset_n, clkEn, outEnable_n, shiftClk, dataIn, recirculate, dataOut, dataOutEn;
   int n_errors = 0;
   int check_count = 0;
   logic [31:0] rows [2] = '{32'hC3A5_0F69, 32'h8000_0001};
   logic [31:0] old = 32'h0;
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   shift_driver u_drv(.clk(clk), .shiftClk(shiftClk), .dataIn(dataIn), .recirculate(recirculate));
   recirc_shift_reg #(.LEN(SHORT_LEN)) u_dut(.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
      .shiftClk(shiftClk), .dataIn(dataIn), .recirculate(recirculate),
      .outEnable_n(outEnable_n), .dataOut(dataOut), .dataOutEn(dataOutEn));
   // =====================
   // compare and report
   task automatic check(input logic seen, input logic exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: saw %b want %b", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // =====================
   // rows: write a word, then rotate it once round
   initial
   begin
      reset_n     = 1'b0;
      clkEn       = 1'b1;
      outEnable_n = 1'b0;
      repeat (10) @(negedge clk);
      check(dataOut, 1'b0);
      check(dataOutEn, 1'b0);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      check(dataOutEn, 1'b1);
      for (int r = 0; r < 2; r++)
      begin
         for (int i = 0; i < 32; i++)
         begin
            u_drv.pulse(rows[r][i], 1'b0);
            check(dataOut, (i < 31) ? old[i+1] : rows[r][0]);
         end
         for (int i = 0; i < 32; i++)
         begin
            u_drv.pulse(1'b0, 1'b1);
            check(dataOut, rows[r][(i+1)%32]);
         end
         old = rows[r];
      end
      // tri-state while disabled, then tail bit back
      outEnable_n = 1'b1;
      repeat (4) @(negedge clk);
      check(dataOutEn, 1'b0);
      outEnable_n = 1'b0;
      repeat (4) @(negedge clk);
      check(dataOutEn, 1'b1);
      check(dataOut, old[0]);
      // frozen clock enable misses a pulse
      clkEn = 1'b0;
      u_drv.pulse(~old[0], 1'b0);
      clkEn = 1'b1;
      repeat (4) @(negedge clk);
      check(dataOut, old[0]);
      // long park high keeps the contents
      repeat (100) @(negedge clk);
      check(dataOut, old[0]);
      // reset again mid-run, chain must restart empty
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      check(dataOut, 1'b0);
      check(dataOutEn, 1'b0);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      check(dataOutEn, 1'b1);
      for (int i = 0; i < 32; i++)
      begin
         u_drv.pulse(1'b1, 1'b0);
         check(dataOut, i == 31);
      end
      tally_and_finish();
   end
endmodule // testbench
